// ---- design/cmd_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
// Operation
// RL1: 100 prefix selects software command fields
// RL2: Toggle bit copied into status bit 11
// RL3: Code 0x555 resets all logic, registers; the code keeps tick_sync and tick_prev through the soft reset
// RL4: Host sends 0x195 before watchdog timeout
// RL5: Missed keep-alive raises alert when enabled
// RL6: 011 prefix writes boost control, ignores 12:7
// RL7: Bit 6 selects internal or external compensation
// RL8: Bits 5:4 set channel clock phases
// RL9: Bits 3:2 pick divided switching rate
// RL10: Bits 1:0 set boost voltage limit
// RL11: Per-channel slew setting held and applied
// RL12: Frequency code 11 stored, treated reserved
module cmd_regs #(
	parameter logic [23:0] WDOG_TIMEOUT = cmd_regs_pkg::WDOG_TIMEOUT_RST
) (
	// Clock and reset
	input  wire logic                         sys_clk_in,
	input  wire logic                         rst_in,
	input  wire logic                         clk_en_in,
	// Decoded command word from the serial receiver
	input  wire logic                         word_valid_in,
	input  wire logic [cmd_regs_pkg::WORD_W-1:0] word_in,
	input  wire logic [1:0]                   slew_chan_in,
	input  wire logic                         wdog_enable_in,
	// Osc tick (13 MHz domain, already a pin level)
	input  wire logic                         osc_tick_in,
	// Outputs
	output var  logic [cmd_regs_pkg::WORD_W-1:0] status_out,
	output var  logic                         soft_reset_out,
	output var  logic                         alert_out,
	output var  logic                         boost_comp_select_out,
	output var  logic [1:0]                   boost_phase_select_out,
	output var  logic [1:0]                   boost_freq_select_out,
	output var  logic [1:0]                   boost_voltage_limit_out,
	output var  logic                         freq_reserved_out,
	output var  logic [cmd_regs_pkg::CHAN_N-1:0] chan_clk_out,
	output var  logic [cmd_regs_pkg::CHAN_N-1:0] slew_enable_out,
	output var  logic [cmd_regs_pkg::SLEW_W-1:0] slew_setting_out
);
	import cmd_regs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic              toggle;
		logic              rst_pend;
		logic              comp;
		logic [1:0]        phase;
		logic [1:0]        freq;
		logic [1:0]        vlim;
		logic [WDOG_W-1:0] wdog_cnt;
		logic              alert;
		logic [CHAN_N-1:0] slew_en;
		logic [1:0]        tick_sync;
		logic              tick_prev;
		logic [7:0]        div_cnt;
		logic [1:0]        quarter;
	} state_t;

	state_t     st_q;
	state_t     st_d;
	logic       sw_hit;
	logic       boost_hit;
	logic       slew_hit;
	logic       tick_rise;
	logic [7:0] div_lim;
	logic       half_flip;

	assign sw_hit    = word_valid_in && word_in[WORD_W-1:TOP_POS] == SW_CMD_ID;    // see RL1
	assign boost_hit = word_valid_in && word_in[WORD_W-1:TOP_POS] == BOOST_CMD_ID; // see RL6
	assign slew_hit  = word_valid_in && word_in[WORD_W-1:TOP_POS] == SLEW_CMD_ID;
	assign tick_rise = st_q.tick_sync[1] && !st_q.tick_prev;

	// Divider limit per frequency code; reserved code reuses the default rate
	always_comb begin
		case (st_q.freq) // see RL9
			2'h0:    div_lim = 8'(DIV_250 / 4);
			2'h2:    div_lim = 8'(DIV_650 / 4);
			default: div_lim = 8'(DIV_410 / 4); // see RL12
		endcase
	end
	assign half_flip = tick_rise && st_q.div_cnt >= div_lim - 8'h01;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_d = st_q;
		st_d.tick_sync = {st_q.tick_sync[0], osc_tick_in};
		st_d.tick_prev = st_q.tick_sync[1];
		st_d.rst_pend  = 1'b0;
		if (tick_rise) begin
			st_d.div_cnt = half_flip ? 8'h00 : st_q.div_cnt + 8'h01;
		end
		if (half_flip) begin
			st_d.quarter = st_q.quarter + 2'h1;
		end
		if (sw_hit) begin
			st_d.toggle = word_in[TOGGLE_POS]; // see RL2
			if (word_in[11:0] == RESET_CODE) begin
				st_d.rst_pend = 1'b1; // see RL3
			end
		end
		// Keep-alive restarts the watchdog
		if (!wdog_enable_in || (sw_hit && word_in[11:0] == KEEPALIVE_CODE)) begin
			st_d.wdog_cnt = '0; // see RL4
		end else if (st_q.wdog_cnt >= WDOG_TIMEOUT - 24'h000001) begin
			st_d.alert = 1'b1; // see RL5
		end else begin
			st_d.wdog_cnt = st_q.wdog_cnt + 24'h000001;
		end
		if (boost_hit) begin
			st_d.comp  = word_in[COMP_POS];         // see RL7
			st_d.phase = word_in[PHASE_POS +: 2];  // see RL8
			st_d.freq  = word_in[FREQ_POS +: 2];   // see RL12
			st_d.vlim  = word_in[VLIM_POS +: 2];   // see RL10
		end
		if (slew_hit) begin
			st_d.slew_en[slew_chan_in] = word_in[SLEW_EN_POS]; // see RL11
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q <= '{toggle: 1'b0, rst_pend: 1'b0, comp: COMP_RST, phase: PHASE_RST,
			          freq: FREQ_RST, vlim: VLIM_RST, wdog_cnt: '0, alert: 1'b0,
			          slew_en: '0, tick_sync: 2'h0, tick_prev: 1'b0, div_cnt: 8'h00,
			          quarter: 2'h0};
		end else if (clk_en_in) begin
			if (st_q.rst_pend) begin
				st_q <= '{toggle: 1'b0, rst_pend: 1'b0, comp: COMP_RST, phase: PHASE_RST,
				          freq: FREQ_RST, vlim: VLIM_RST, wdog_cnt: '0, alert: 1'b0,
				          slew_en: '0, tick_sync: st_d.tick_sync, tick_prev: st_d.tick_prev,
				          div_cnt: 8'h00, quarter: 2'h0}; // see RL3
			end else begin
				st_q <= st_d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Slew settings live in a small per-channel store
	slew_store #(
		.DEPTH (CHAN_N),
		.WIDTH (SLEW_W)
	) slew_store_inst (
		.sys_clk_in  (sys_clk_in),
		.rst_in      (rst_in || st_q.rst_pend),
		.clk_en_in   (clk_en_in),
		.wr_en_in    (slew_hit),
		.wr_addr_in  (slew_chan_in),
		.wr_data_in  (word_in[SLEW_W-1:0]),
		.rd_addr_in  (slew_chan_in),
		.rd_data_out (slew_setting_out)
	); // see RL11

	// Channel clock phases from a four-step sequence
	logic base_clk;
	logic quad_clk [CHAN_N];
	assign base_clk = st_q.quarter[1];
	genvar g;
	generate
		for (g = 0; g < CHAN_N; g++) begin : g_ch
			assign quad_clk[g] = (st_q.quarter - 2'(g)) >= 2'h2;
			always_comb begin
				case (st_q.phase) // see RL8
					2'h0:    chan_clk_out[g] = base_clk;
					2'h1:    chan_clk_out[g] = (g >= 2) ? !base_clk : base_clk;
					2'h2:    chan_clk_out[g] = (g % 2 == 1) ? !base_clk : base_clk;
					default: chan_clk_out[g] = quad_clk[g];
				endcase
			end
		end
	endgenerate

	always_comb begin
		status_out                = '0;
		status_out[STATUS_TOGGLE] = st_q.toggle; // see RL2
	end
	assign soft_reset_out          = st_q.rst_pend;
	assign alert_out               = st_q.alert && wdog_enable_in; // see RL5
	assign boost_comp_select_out   = st_q.comp;
	assign boost_phase_select_out  = st_q.phase;
	assign boost_freq_select_out   = st_q.freq;
	assign boost_voltage_limit_out = st_q.vlim;
	assign freq_reserved_out       = st_q.freq == FREQ_RESERVED; // see RL12
	assign slew_enable_out         = st_q.slew_en;

	////////////////////////////////////////////////////////////////////////
	sequence reset_word_s;
		sw_hit && word_in[11:0] == RESET_CODE && clk_en_in && !soft_reset_out;
	endsequence

	// A word that lands while the soft reset is pending is lost, so it is left out below
	toggle_copy_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see RL2
		sw_hit && clk_en_in && !soft_reset_out && word_in[11:0] != RESET_CODE
		|=> status_out[STATUS_TOGGLE] == $past(word_in[TOGGLE_POS]))
		else $error("toggle bit not mirrored");
	soft_reset_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see RL3
		reset_word_s |=> soft_reset_out ##1 (boost_freq_select_out == FREQ_RST && status_out == '0))
		else $error("reset code did not reset");
	boost_write_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see RL6
		boost_hit && clk_en_in && !soft_reset_out
		|=> boost_voltage_limit_out == $past(word_in[1:0]) && boost_freq_select_out == $past(word_in[3:2]))
		else $error("boost write lost");
	comp_write_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see RL7
		boost_hit && clk_en_in && !soft_reset_out |=> boost_comp_select_out == $past(word_in[COMP_POS]))
		else $error("compensation bit wrong");
	phase_write_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see RL8
		boost_hit && clk_en_in && !soft_reset_out |=> boost_phase_select_out == $past(word_in[5:4]))
		else $error("phase field wrong");
	phase_same_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see RL8
		boost_phase_select_out == 2'h0 |-> chan_clk_out == {CHAN_N{chan_clk_out[0]}})
		else $error("channels not on one edge");
	alert_off_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see RL5
		!wdog_enable_in && !st_q.alert |=> !st_q.alert)
		else $error("alert with watchdog off");
	keepalive_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see RL4
		sw_hit && clk_en_in && word_in[11:0] == KEEPALIVE_CODE && !st_q.alert |=> !alert_out[*2])
		else $error("alert after keep-alive");
	reserved_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see RL12
		freq_reserved_out |-> boost_freq_select_out == 2'h3 && div_lim == 8'(DIV_410 / 4))
		else $error("reserved flag wrong");
	slew_en_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see RL11
		slew_hit && clk_en_in && !st_q.rst_pend |=> slew_enable_out[$past(slew_chan_in)] == $past(word_in[SLEW_EN_POS]))
		else $error("slew enable lost");
	freq_div_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see RL9
		boost_freq_select_out == 2'h0 |-> div_lim == 8'(DIV_250 / 4))
		else $error("divider wrong");
	sw_decode_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see RL1
		sw_hit |-> !boost_hit && word_in[15:13] == 3'h4)
		else $error("software decode wrong");
endmodule
`default_nettype wire

// ---- design/cmd_regs_pkg.sv ----
`default_nettype none
package cmd_regs_pkg;
	localparam int          WORD_W          = 16;
	localparam int          CHAN_N          = 4;
	localparam logic [2:0]  SW_CMD_ID       = 3'h4;
	localparam logic [2:0]  BOOST_CMD_ID    = 3'h3;
	localparam logic [2:0]  SLEW_CMD_ID     = 3'h0;
	localparam int          TOP_POS         = 13;
	localparam int          TOGGLE_POS      = 12;
	localparam int          SLEW_EN_POS     = 12;
	localparam int          STATUS_TOGGLE   = 11;
	localparam logic [11:0] RESET_CODE      = 12'h555;
	localparam logic [11:0] KEEPALIVE_CODE  = 12'h195;
	localparam int          COMP_POS        = 6;
	localparam int          PHASE_POS       = 4;
	localparam int          FREQ_POS        = 2;
	localparam int          VLIM_POS        = 0;
	localparam logic        COMP_RST        = 1'b0;
	localparam logic [1:0]  PHASE_RST       = 2'h0;
	localparam logic [1:0]  FREQ_RST        = 2'h1;
	localparam logic [1:0]  VLIM_RST        = 2'h0;
	localparam logic [1:0]  FREQ_RESERVED   = 2'h3;
	localparam int          OSC_KHZ         = 13000;
	localparam int          FREQ_250_KHZ    = 250;
	localparam int          FREQ_410_KHZ    = 410;
	localparam int          FREQ_650_KHZ    = 650;
	localparam int          DIV_250         = OSC_KHZ / FREQ_250_KHZ;
	localparam int          DIV_410         = OSC_KHZ / FREQ_410_KHZ;
	localparam int          DIV_650         = OSC_KHZ / FREQ_650_KHZ;
	localparam int          SLEW_W          = 7;
	localparam int          WDOG_W          = 24;
	localparam logic [23:0] WDOG_TIMEOUT_RST = 24'h00c350;
endpackage
`default_nettype wire

// ---- design/slew_store.sv ----
`timescale 1ns/10ps
`default_nettype none
module slew_store #(
	parameter int DEPTH = 4,
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic                     sys_clk_in,
	input  wire logic                     rst_in,
	input  wire logic                     clk_en_in,
	// Write and read
	input  wire logic                     wr_en_in,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
	input  wire logic [WIDTH-1:0]         wr_data_in,
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
	output var  logic [WIDTH-1:0]         rd_data_out
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
			rd_data_out <= '0;
		end else if (clk_en_in) begin
			if (wr_en_in) begin
				mem_q[wr_addr_in] <= wr_data_in;
			end
			rd_data_out <= mem_q[rd_addr_in];
		end
	end
endmodule
`default_nettype wire

// ---- testbench/host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module host_model (
	// Clock
	input  wire logic        sys_clk_in,
	// Command word
	output var  logic        word_valid_out,
	output var  logic [15:0] word_out,
	output var  logic [1:0]  slew_chan_out
);
	import cmd_regs_pkg::*;
	initial begin
		word_valid_out = 1'b0;
		word_out       = 16'h0000;
		slew_chan_out  = 2'h0;
	end
	// Whole word with a one-cycle strobe; the bus is scrambled once released
	task automatic send(input logic [15:0] w, input logic [1:0] ch);
		@(posedge sys_clk_in);
		#1;
		word_valid_out = 1'b1;
		word_out       = w;
		slew_chan_out  = ch;
		@(posedge sys_clk_in);
		#1;
		word_valid_out = 1'b0;
		word_out       = ~w;
	endtask
	task automatic keep_alive(input int n, input int gap);
		repeat (n) begin
			send({SW_CMD_ID, 1'b0, KEEPALIVE_CODE}, slew_chan_out);
			repeat (gap) @(posedge sys_clk_in);
			#1;
		end
	endtask
endmodule
`default_nettype wire

// ---- testbench/cmd_regs_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module cmd_regs_bench;
	import cmd_regs_pkg::*;
	logic              sys_clk_in, rst_in, clk_en_in, word_valid_in, wdog_enable_in, osc_tick_in;
	logic              soft_reset_out, alert_out, comp, freq_res, bad, diff;
	logic [WORD_W-1:0] word_in, status_out;
	logic [1:0]        slew_chan_in, phase, freq, vlim, v;
	logic [CHAN_N-1:0] chan_clk, slew_en;
	logic [SLEW_W-1:0] slew_set;
	int                mismatches, checks_done, pulses;
	int                first_chg, span, exp_span;
	logic              prev_clk;
	// Oscillator period in system clocks
	localparam int     OSC_CYC = 8;
	////////////////////////////////////////////////////////////////
	host_model host_model_inst (.sys_clk_in(sys_clk_in), .word_valid_out(word_valid_in),
		.word_out(word_in), .slew_chan_out(slew_chan_in));
	cmd_regs #(.WDOG_TIMEOUT(24'h000014)) cmd_regs_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.clk_en_in(clk_en_in), .word_valid_in(word_valid_in), .word_in(word_in),
		.slew_chan_in(slew_chan_in), .wdog_enable_in(wdog_enable_in), .osc_tick_in(osc_tick_in),
		.status_out(status_out), .soft_reset_out(soft_reset_out), .alert_out(alert_out),
		.boost_comp_select_out(comp), .boost_phase_select_out(phase), .boost_freq_select_out(freq),
		.boost_voltage_limit_out(vlim), .freq_reserved_out(freq_res), .chan_clk_out(chan_clk),
		.slew_enable_out(slew_en), .slew_setting_out(slew_set));
	////////////////////////////////////////////////////////////////
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		osc_tick_in = 1'b0;
		forever begin
			repeat (OSC_CYC / 2) @(posedge sys_clk_in);
			#1;
			osc_tick_in = ~osc_tick_in;
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	task automatic test_done();
		if (mismatches == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		mismatches++;
		test_done();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		rst_in         = 1'b1;
		clk_en_in      = 1'b1;
		wdog_enable_in = 1'b0;
		mismatches     = 0;
		checks_done    = 0;
		wait_cyc(10);
		rst_in = 1'b0;
		chk(comp, COMP_RST);
		chk(phase, PHASE_RST);
		chk(freq, FREQ_RST);
		chk(vlim, VLIM_RST);
		chk(status_out, 16'h0000);
		// Every field code, with the ignored bits all set
		for (int i = 0; i < 4; i++) begin
			v = i[1:0];
			host_model_inst.send({BOOST_CMD_ID, 6'h3f, v[0], v, v, v}, 2'h0);
			wait_cyc(1);
			chk(comp, v[0]);
			chk(phase, v);
			chk(freq, v);
			chk(vlim, v);
			chk(freq_res, v == FREQ_RESERVED);
			bad       = 1'b0;
			diff      = 1'b0;
			first_chg = -1;
			span      = 0;
			prev_clk  = chan_clk[0];
			// Channel clock half period is two quarter steps of div/4 oscillator ticks
			exp_span  = 2 * OSC_CYC * ((v == 2'h0) ? DIV_250 / 4 : (v == 2'h2) ? DIV_650 / 4 : DIV_410 / 4);
			for (int c = 0; c < 500; c++) begin
				wait_cyc(1);
				if (v == 2'h0 && chan_clk !== {CHAN_N{chan_clk[0]}}) bad = 1'b1;
				if (v == 2'h1 && (chan_clk[1] !== chan_clk[0] || chan_clk[3] !== chan_clk[2])) bad = 1'b1;
				if (v == 2'h2 && (chan_clk[2] !== chan_clk[0] || chan_clk[3] !== chan_clk[1])) bad = 1'b1;
				if (v == 2'h3 && $countones(chan_clk) != 2) bad = 1'b1;
				if (chan_clk[0] !== chan_clk[(v == 2'h2) ? 1 : 2]) diff = 1'b1;
				if (chan_clk[0] !== prev_clk && first_chg >= 0 && span == 0) span = c - first_chg;
				if (chan_clk[0] !== prev_clk && first_chg < 0) first_chg = c;
				prev_clk = chan_clk[0];
			end
			chk(bad, 1'b0);
			chk(diff, v != 2'h0);
			chk(span[15:0], exp_span[15:0]);
		end
		host_model_inst.send(16'h5fff, 2'h0);
		wait_cyc(1);
		chk({comp, phase, freq, vlim}, 7'h7f);
		chk(status_out, 16'h0000);
		host_model_inst.send({SW_CMD_ID, 1'b1, 12'h000}, 2'h0);
		wait_cyc(1);
		chk(status_out, 16'h0800);
		host_model_inst.send({SW_CMD_ID, 1'b0, 12'h000}, 2'h0);
		wait_cyc(1);
		chk(status_out, 16'h0000);
		// Two channels written, each read back after the other
		host_model_inst.send({SLEW_CMD_ID, 1'b1, 5'h00, 7'h2a}, 2'h2);
		host_model_inst.send({SLEW_CMD_ID, 1'b0, 5'h1f, 7'h15}, 2'h1);
		wait_cyc(2);
		chk(slew_en, 4'h4);
		chk(slew_set, 7'h15);
		host_model_inst.send(16'h5000, 2'h2);
		wait_cyc(2);
		chk(slew_set, 7'h2a);
		// A word offered while the clock enable is low must not land
		clk_en_in = 1'b0;
		host_model_inst.send({BOOST_CMD_ID, 13'h0000}, 2'h0);
		clk_en_in = 1'b1;
		wait_cyc(1);
		chk(vlim, 2'h3);
		wdog_enable_in = 1'b1;
		host_model_inst.keep_alive(4, 10);
		chk(alert_out, 1'b0);
		wait_cyc(30);
		chk(alert_out, 1'b1);
		wdog_enable_in = 1'b0;
		wait_cyc(2);
		chk(alert_out, 1'b0);
		host_model_inst.send({SW_CMD_ID, 1'b1, RESET_CODE}, 2'h0);
		pulses = 0;
		repeat (4) begin
			if (soft_reset_out === 1'b1) pulses++;
			wait_cyc(1);
		end
		chk(pulses[15:0], 16'h0001);
		chk({comp, phase, freq, vlim}, {COMP_RST, PHASE_RST, FREQ_RST, VLIM_RST});
		chk(slew_en, 4'h0);
		chk(status_out, 16'h0000);
		test_done();
	end
endmodule
`default_nettype wire
